// File: design/pisosr_fifo.sv
`timescale 1ns/100ps
module pisosr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk, // clock
  input wire logic rst, // sync reset, high
  pisosr_fifo_if.fifo port // both sides
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic [WIDTH-1:0] dout_reg, dout_next;
  logic vld_reg, vld_next;
  logic do_wr, do_rd;

  assign port.in_ready = (cnt_reg != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign port.out_valid = vld_reg;
  assign port.out_data = dout_reg;

  always_comb begin
    do_wr = port.in_valid && port.in_ready;
    // output register refills whenever empty or consumed and cnt_reg is nonzero
    do_rd = (cnt_reg != '0) && (!vld_reg || port.out_ready);
    wr_next = do_wr ? AW'(wr_reg + 1'b1) : wr_reg;
    rd_next = do_rd ? AW'(rd_reg + 1'b1) : rd_reg;
    cnt_next = cnt_reg;
    if (do_wr && !do_rd) begin
      cnt_next = (AW+1)'(cnt_reg + 1'b1);
    end else if (do_rd && !do_wr) begin
      cnt_next = (AW+1)'(cnt_reg - 1'b1);
    end
    dout_next = do_rd ? mem[rd_reg] : dout_reg;
    vld_next = do_rd ? 1'b1 : (port.out_ready ? 1'b0 : vld_reg);
  end

  always_ff @(posedge ref_clk) begin
    if (do_wr) begin
      mem[wr_reg] <= port.in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      dout_reg <= '0;
      vld_reg <= 1'b0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
      dout_reg <= dout_next;
      vld_reg <= vld_next;
    end
  end
endmodule : pisosr_fifo

// File: design/pisosr_fifo_if.sv
`timescale 1ns/100ps
interface pisosr_fifo_if #(parameter int WIDTH = 8) ();
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [WIDTH-1:0] out_data;
  modport fifo (input in_valid, output in_ready, input in_data,
                output out_valid, input out_ready, output out_data);
  modport user (output in_valid, input in_ready, output in_data,
                input out_valid, output out_ready, input out_data);
endinterface : pisosr_fifo_if

// File: design/pisosr_pkg.sv
package pisosr_pkg;
  localparam int PISOSR_STAGES = 8;
  localparam int PISOSR_FIFO_DEPTH = 32;
  localparam int PISOSR_CLK_PERIOD_NS = 100;
  localparam logic [7:0] PISOSR_STAGE_RESET = 8'h00;
  localparam int PISOSR_LAST_POS = PISOSR_STAGES - 1;
  localparam int PISOSR_FIRST_POS = 0;
endpackage : pisosr_pkg

// File: design/pisosr_top.sv
`timescale 1ns/100ps
// Overview of operation
// - eight stages chained, parallel or serial fill
// - load low copies parallel inputs, no edge
// - shift on edge, serial into first stage
// - last stage on true and inverse outputs
// - cascade: last output feeds next serial input
module pisosr_top
  import pisosr_pkg::*;
#(
  parameter int STAGES = PISOSR_STAGES,
  parameter int FIFO_DEPTH = PISOSR_FIFO_DEPTH
) (
  input wire logic ref_clk, // system clock
  input wire logic rst, // sync reset, high
  input wire logic shift_clk, // shift clock pin
  input wire logic shift_not_load, // low loads, high shifts
  input wire logic clock_inhibit, // high freezes
  input wire logic serial_in, // cascade input
  input wire logic [STAGES-1:0] par_in, // parallel data, bit 0 first stage
  output logic last_stage_out, // last stage
  output logic last_stage_out_n, // inverted last stage
  output logic [STAGES-1:0] stage_q, // stage contents
  output logic bit_valid, // shifted-out bit available
  output logic bit_out, // shifted-out bit
  input wire logic bit_ready, // consumer takes bit
  output logic bit_overflow // stream bit dropped, fifo full
);
  // one-hot mode of the cycle; load outranks inhibit and the clock edge
  typedef enum logic [3:0] {
    PISOSR_MODE_IDLE = 4'h1,
    PISOSR_MODE_LOAD = 4'h2,
    PISOSR_MODE_SHIFT = 4'h4,
    PISOSR_MODE_HOLD = 4'h8
  } pisosr_mode_e;

  // pin inputs pass two flops; every pin may change at any ref_clk phase
  logic clk_s1_reg;
  logic clk_s1_next;
  logic clk_s2_reg;
  logic clk_s2_next;
  logic load_n_s1_reg;
  logic load_n_s1_next;
  logic load_n_s2_reg;
  logic load_n_s2_next;
  logic inh_s1_reg;
  logic inh_s1_next;
  logic inh_s2_reg;
  logic inh_s2_next;
  logic ser_s1_reg;
  logic ser_s1_next;
  logic ser_s2_reg;
  logic ser_s2_next;
  logic [STAGES-1:0] par_s1_reg;
  logic [STAGES-1:0] par_s1_next;
  logic [STAGES-1:0] par_s2_reg;
  logic [STAGES-1:0] par_s2_next;

  logic clk_prev_reg;
  logic clk_prev_next;
  logic rise;
  pisosr_mode_e mode;
  logic [STAGES-1:0] stage_reg;
  logic [STAGES-1:0] stage_next;
  logic [STAGES-1:0] shift_vec;
  logic out_reg;
  logic out_next;
  logic out_n_reg;
  logic out_n_next;
  logic ovf_reg;
  logic ovf_next;
  logic push;

  function automatic pisosr_mode_e pisosr_decode(
    input logic load_n, // synced shift_not_load
    input logic inhibit, // synced clock_inhibit
    input logic edge_seen // synced clock rose
  );
    pisosr_mode_e mode_v;
    mode_v = PISOSR_MODE_IDLE;
    if (!load_n) begin
      mode_v = PISOSR_MODE_LOAD;
    end else if (inhibit) begin
      mode_v = PISOSR_MODE_HOLD;
    end else if (edge_seen) begin
      mode_v = PISOSR_MODE_SHIFT;
    end
    return mode_v;
  endfunction : pisosr_decode

  pisosr_fifo_if #(.WIDTH(1)) fif ();

  pisosr_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .port(fif)
  );

  always_comb begin
    clk_s1_next = shift_clk;
    clk_s2_next = clk_s1_reg;
    load_n_s1_next = shift_not_load;
    load_n_s2_next = load_n_s1_reg;
    inh_s1_next = clock_inhibit;
    inh_s2_next = inh_s1_reg;
    // serial level travels with the clock, so the level set up before the edge wins
    ser_s1_next = serial_in;
    ser_s2_next = ser_s1_reg;
    par_s1_next = par_in;
    par_s2_next = par_s1_reg;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clk_s1_reg <= 1'b0;
      clk_s2_reg <= 1'b0;
      load_n_s1_reg <= 1'b0;
      load_n_s2_reg <= 1'b0;
      inh_s1_reg <= 1'b0;
      inh_s2_reg <= 1'b0;
      ser_s1_reg <= 1'b0;
      ser_s2_reg <= 1'b0;
      par_s1_reg <= '0;
      par_s2_reg <= '0;
    end else begin
      clk_s1_reg <= clk_s1_next;
      clk_s2_reg <= clk_s2_next;
      load_n_s1_reg <= load_n_s1_next;
      load_n_s2_reg <= load_n_s2_next;
      inh_s1_reg <= inh_s1_next;
      inh_s2_reg <= inh_s2_next;
      ser_s1_reg <= ser_s1_next;
      ser_s2_reg <= ser_s2_next;
      par_s1_reg <= par_s1_next;
      par_s2_reg <= par_s2_next;
    end
  end

  // a rise seen while inhibited is used up, so lowering inhibit never shifts
  always_comb begin
    clk_prev_next = clk_s2_reg;
    rise = clk_s2_reg && !clk_prev_reg;
    mode = pisosr_decode(load_n_s2_reg, inh_s2_reg, rise);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clk_prev_reg <= 1'b0;
    end else begin
      clk_prev_reg <= clk_prev_next;
    end
  end

  // each stage takes its upstream neighbour; the first takes the serial pin
  for (genvar gi = 0; gi < STAGES; gi++) begin : g_stage
    if (gi == PISOSR_FIRST_POS) begin : g_first
      assign shift_vec[gi] = ser_s2_reg;
    end else begin : g_chain
      assign shift_vec[gi] = stage_reg[gi-1];
    end
  end

  always_comb begin
    stage_next = stage_reg;
    push = 1'b0;
    case (mode)
      PISOSR_MODE_LOAD: begin
        // level load, not edge: sampled every cycle while low
        stage_next = par_s2_reg;
      end
      PISOSR_MODE_SHIFT: begin
        stage_next = shift_vec;
        push = 1'b1;
      end
      PISOSR_MODE_HOLD: begin
        stage_next = stage_reg;
      end
      PISOSR_MODE_IDLE: begin
        stage_next = stage_reg;
      end
      default: begin
        stage_next = stage_reg;
      end
    endcase
    // outputs track the stage value being stored, so a load shows at once
    out_next = stage_next[STAGES-1];
    out_n_next = ~stage_next[STAGES-1];
    // bit lost only if stream consumer stalls until the fifo fills
    ovf_next = ovf_reg || (push && !fif.in_ready);
  end

  always_comb begin
    fif.in_valid = push;
    fif.in_data = stage_reg[STAGES-1];
    fif.out_ready = bit_ready;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stage_reg <= PISOSR_STAGE_RESET[STAGES-1:0];
      out_reg <= 1'b0;
      out_n_reg <= 1'b1;
      ovf_reg <= 1'b0;
    end else begin
      stage_reg <= stage_next;
      out_reg <= out_next;
      out_n_reg <= out_n_next;
      ovf_reg <= ovf_next;
    end
  end

  assign last_stage_out = out_reg;
  assign last_stage_out_n = out_n_reg;
  assign stage_q = stage_reg;
  assign bit_valid = fif.out_valid;
  assign bit_out = fif.out_data;
  assign bit_overflow = ovf_reg;
endmodule : pisosr_top

// File: tb/pisosr_ctrl_model.sv
`timescale 1ns/100ps
module pisosr_ctrl_model (
  input wire logic ref_clk, // clock
  output logic shift_clk = 0, // pin clock
  output logic shift_not_load = 1, // mode
  output logic clock_inhibit = 0, // freeze
  output logic serial_in = 0, // serial
  output logic [7:0] par_in = 0 // data
);
  logic hold = 0;
  task load(input logic [7:0] d); // inhibit low first; clock left as is
    clock_inhibit = 0;
    shift_not_load = 0;
    par_in = d;
    repeat (5) @(negedge ref_clk);
    shift_not_load = 1;
    repeat (4) @(negedge ref_clk);
  endtask : load
  task pulse(input logic s);
    serial_in = s;
    repeat (4) @(negedge ref_clk);
    shift_clk = 1;
    repeat (4) @(negedge ref_clk);
    clock_inhibit = hold; // only while clock high
    @(negedge ref_clk);
    shift_clk = 0;
  endtask : pulse
endmodule : pisosr_ctrl_model

// File: tb/pisosr_props.sv
`timescale 1ns/100ps
module pisosr_props (
  input wire logic ref_clk, // clock
  input wire logic rst, // reset
  input wire logic shift_not_load, // mode
  input wire logic clock_inhibit, // freeze
  input wire logic serial_in, // serial
  input wire logic [7:0] par_in, // data
  input wire logic [7:0] stage_q, // stages
  input wire logic last_stage_out, // out
  input wire logic last_stage_out_n, // inverse
  input wire logic bit_valid, // valid
  input wire logic bit_ready, // ready
  input wire logic bit_out // bit
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  load_copy_a: assert property (
    (!shift_not_load && $stable(par_in))[*4] |-> stage_q == par_in) else $error("load");
  shift_move_a: assert property (
    shift_not_load[*5] ##0 $changed(stage_q) |->
    stage_q == {$past(stage_q[6:0]), $past(serial_in, 3)}) else $error("shift");
  inhibit_hold_a: assert property (
    (shift_not_load && clock_inhibit)[*5] |-> $stable(stage_q)) else $error("freeze");
  out_true_a: assert property (last_stage_out == stage_q[7]) else $error("out");
  out_inv_a: assert property (last_stage_out_n != last_stage_out) else $error("inv");
  bit_hold_a: assert property (
    bit_valid && !bit_ready |=> bit_valid && $stable(bit_out)) else $error("stream");
endmodule : pisosr_props

// File: tb/pisosr_test.sv
`timescale 1ns/100ps
module pisosr_test;
  logic ref_clk = 0, rst = 1, bit_ready = 0, stall = 0, fz = 0;
  logic shift_clk, shift_not_load, clock_inhibit, serial_in, bit_valid, bit_out;
  logic bit_overflow, last_stage_out, last_stage_out_n;
  logic [7:0] par_in, stage_q, want;
  logic q[$];
  int error_cnt = 0, checks = 0, seed = 80;
  initial forever #50 ref_clk = ~ref_clk;
  pisosr_ctrl_model ctl (.ref_clk, .shift_clk, .shift_not_load, .clock_inhibit,
    .serial_in, .par_in);
  pisosr_top dut (.ref_clk, .rst, .shift_clk, .shift_not_load, .clock_inhibit, .serial_in,
    .par_in, .last_stage_out, .last_stage_out_n, .stage_q, .bit_valid, .bit_out,
    .bit_ready, .bit_overflow);
  task chk(string n, logic [7:0] e, logic [7:0] s);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task end_of_test;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test
  task step(input int v);
    if (!fz) begin
      if (q.size() < 32)
        q.push_back(want[7]);
      want = {want[6:0], v[0]};
    end
    ctl.hold = v[1];
    ctl.pulse(v[0]);
    fz = v[1];
    chk("shift", want, stage_q);
    chk("out", {want[7], ~want[7]}, {last_stage_out, last_stage_out_n});
  endtask : step
  always @(negedge ref_clk) bit_ready <= !stall & $random(seed);
  always @(posedge ref_clk)
    if (bit_valid === 1'b1 && bit_ready && q.size() > 0)
      chk("bit", q.pop_front(), bit_out);
  initial begin
    repeat (20) @(negedge ref_clk);
    rst = 0;
    @(negedge ref_clk);
    chk("reset", 8'h01, {stage_q[3:0], bit_overflow, bit_valid, last_stage_out,
      last_stage_out_n});
    for (int i = 0; i < 6; i++) begin
      want = i < 2 ? 8'h80 >> (7 * i) : 8'($random(seed));
      ctl.load(want);
      chk("load", want, stage_q);
    end
    for (int i = 0; i < 24; i++)
      step(i < 20 ? $random(seed) : 0);
    repeat (100) if (q.size() > 0) @(negedge ref_clk);
    stall = 1;
    repeat (34) step(0);
    chk("overflow", 8'h01, bit_overflow);
    stall = 0;
    repeat (150) @(negedge ref_clk);
    chk("drain", 8'h00, q.size());
    end_of_test;
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    error_cnt++;
    end_of_test;
  end
endmodule : pisosr_test
bind pisosr_top pisosr_props props (.ref_clk, .rst, .shift_not_load, .clock_inhibit,
  .serial_in, .par_in, .stage_q, .last_stage_out, .last_stage_out_n, .bit_valid,
  .bit_ready, .bit_out);
